// [core/gtc_regs.vh]
`ifndef GTC_REGS_VH
`define GTC_REGS_VH
// register byte addresses
`define GTC_ADDR_LOW 4'h0
`define GTC_ADDR_HIGH 4'h4
`define GTC_ADDR_CTRL 4'h8
`define GTC_ADDR_CLK 4'hC
`define GTC_ADDR_STAT 5'h10
`define GTC_ADDR_W 5
// control fields
`define GTC_CTRL_ON 0
`define GTC_CTRL_WIDE 1
`define GTC_CTRL_NOSYNC 2
`define GTC_CTRL_GE 3
`define GTC_CTRL_PS_LO 4
`define GTC_CTRL_PS_HI 5
// clock select field and codes
`define GTC_CLK_SEL_LO 0
`define GTC_CLK_SEL_HI 1
`define GTC_CLK_LSO_EN 2
`define GTC_CS_FOSC4 2'h0
`define GTC_CS_FOSC 2'h1
`define GTC_CS_EXT 2'h2
`define GTC_CS_LSO 2'h3
// status fields
`define GTC_STAT_OVF 0
`define GTC_STAT_LSO_RDY 1
// divider select codes
`define GTC_PS_1 2'h0
`define GTC_PS_2 2'h1
`define GTC_PS_4 2'h2
`define GTC_PS_8 2'h3
`define GTC_FOSC_STEP 16'h0004
`define GTC_RESP_OKAY 2'h0
`define GTC_RESP_SLVERR 2'h2
// address bit that selects the status page, and its only offset
`define GTC_ADDR_SEL 4
`define GTC_STAT_OFS 4'h0
`define GTC_UNIT_STEP 16'h0001
`define GTC_PSC_STEP 3'h1
`define GTC_SUM_CARRY 16
`endif

// [core/gtc_timer.v]
// Behaviour
// - 16-bit up-counter, byte writes update count
// - run and gate enable decide counting
// - full-rate oscillator source adds four per tick
// - external source counts on rising edges
// - counter mode needs falling edge first
// - two-bit prescaler divides by 1,2,4,8
// - writing low byte clears prescale counter
// - low-speed oscillator source, runs in sleep
// - unsynchronized external input keeps counting asleep
// - synchronizer stops during sleep
// - one count error allowed at mode switch
// - byte reads return valid count values
// - wide mode routes high byte to shadow
// - low byte read latches high into shadow in wide mode
// - low byte write loads all 16 bits in wide mode, only the low byte otherwise
// - high byte write keeps prescaler
// - wrap to zero sets overflow flag
// - prescale field at control bits 5:4
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "gtc_regs.vh"
module gtc_timer (
   input wire aclk,
   input wire aresetn,
   input wire [4:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire ext_clock_input,
   input wire fosc_tick,
   input wire fosc4_tick,
   input wire lso_clk,
   input wire lso_ready,
   input wire gate_in,
   input wire sleep,
   output wire lso_enable,
   output reg overflow_pulse
);
   reg [15:0] count_ff;
   reg [7:0] shadow_ff;
   reg [5:0] ctrl_ff;
   reg [2:0] clk_ff;
   reg ovf_ff;
   reg [2:0] psc_ff;
   reg src_q_ff;
   reg sync1_ff;
   reg sync2_ff;
   reg armed_ff;
   reg [15:0] nxt_count;
   reg [7:0] nxt_shadow;
   reg [2:0] nxt_psc;
   reg nxt_ovf;
   reg nxt_armed;
   reg [31:0] rd_word;
   reg rd_ok;
   reg [16:0] sum;
   reg tick;
   reg pre_out;
   wire run;
   wire is_ext;
   wire raw_src;
   wire src;
   wire rise;
   wire fall;
   wire wr_go;
   wire rd_go;
   wire wr_low;
   wire wr_high;
   wire rd_low;
   wire [1:0] cs;
   wire [1:0] ps;
   wire [3:0] wa;
   wire [3:0] ra;
   wire [7:0] wb;
   wire [15:0] step;
   wire wr_ctrl;
   wire wr_clk;
   wire wr_stat;
   wire wr_map;
   wire rd_stat;
   wire is_fosc;
   wire is_lso;

   assign cs = clk_ff[`GTC_CLK_SEL_HI:`GTC_CLK_SEL_LO];
   assign ps = ctrl_ff[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO];
   assign lso_enable = clk_ff[`GTC_CLK_LSO_EN];
   assign wa = s_axi_awaddr[3:0];
   assign ra = s_axi_araddr[3:0];
   assign wb = s_axi_wdata[7:0];

   // write address and data are taken together, one outstanding response
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;
   assign wr_low = wr_go && s_axi_wstrb[0] && !s_axi_awaddr[`GTC_ADDR_SEL]
      && wa == `GTC_ADDR_LOW;
   assign wr_high = wr_go && s_axi_wstrb[0] && !s_axi_awaddr[`GTC_ADDR_SEL]
      && wa == `GTC_ADDR_HIGH;
   assign rd_low = rd_go && !s_axi_araddr[`GTC_ADDR_SEL]
      && ra == `GTC_ADDR_LOW;
   // write strobes for the control, clock-select and status registers
   assign wr_ctrl = wr_go && s_axi_wstrb[0] && !s_axi_awaddr[`GTC_ADDR_SEL]
      && wa == `GTC_ADDR_CTRL;
   assign wr_clk = wr_go && s_axi_wstrb[0] && !s_axi_awaddr[`GTC_ADDR_SEL]
      && wa == `GTC_ADDR_CLK;
   assign wr_stat = wr_go && s_axi_wstrb[0] && s_axi_awaddr[`GTC_ADDR_SEL]
      && wa == `GTC_STAT_OFS;
   // unmapped offsets answer with an error and change nothing
   assign wr_map = s_axi_awaddr[`GTC_ADDR_SEL] ? wa == `GTC_STAT_OFS
      : (wa == `GTC_ADDR_LOW || wa == `GTC_ADDR_HIGH
      || wa == `GTC_ADDR_CTRL || wa == `GTC_ADDR_CLK);
   assign rd_stat = s_axi_araddr[`GTC_ADDR_SEL] && ra == `GTC_STAT_OFS;

   // run and gate enable combination
   assign run = ctrl_ff[`GTC_CTRL_ON]
      && (!ctrl_ff[`GTC_CTRL_GE] || gate_in);
   assign is_fosc = cs == `GTC_CS_FOSC;
   assign is_lso = cs == `GTC_CS_LSO;
   assign is_ext = cs == `GTC_CS_EXT || is_lso;
   assign raw_src = is_lso ? lso_clk : ext_clock_input;
   // synchronized path freezes in sleep; bypass follows the raw level
   assign src = ctrl_ff[`GTC_CTRL_NOSYNC] ? raw_src : sync2_ff;
   assign rise = src && !src_q_ff;
   assign fall = !src && src_q_ff;
   assign step = is_fosc ? `GTC_FOSC_STEP : `GTC_UNIT_STEP;

   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else if (!sleep) begin
         sync1_ff <= raw_src;
         sync2_ff <= sync1_ff;
      end
   end

   // prescaler, edge arming and count update
   always @* begin
      nxt_armed = armed_ff;
      nxt_psc = psc_ff;
      tick = 1'b0;
      pre_out = 1'b0;
      if (is_ext) begin
         if (fall) begin
            nxt_armed = 1'b1;
         end
         tick = run && rise && armed_ff;
      end else begin
         tick = run && !sleep && (is_fosc ? fosc_tick : fosc4_tick);
      end
      if (!ctrl_ff[`GTC_CTRL_ON]) begin
         nxt_armed = 1'b0;
      end
      if (tick) begin
         nxt_psc = psc_ff + `GTC_PSC_STEP;
         case (ps)
            `GTC_PS_1: pre_out = 1'b1;
            `GTC_PS_2: pre_out = psc_ff[0];
            `GTC_PS_4: pre_out = &psc_ff[1:0];
            default: pre_out = &psc_ff;
         endcase
      end
      // small mismatch at a sync mode change is accepted
      sum = {1'b0, count_ff} + {1'b0, step};
      nxt_count = count_ff;
      nxt_ovf = ovf_ff;
      nxt_shadow = shadow_ff;
      if (pre_out) begin
         nxt_count = sum[15:0];
         if (sum[`GTC_SUM_CARRY]) begin
            nxt_ovf = 1'b1;
         end
      end
      if (rd_low && ctrl_ff[`GTC_CTRL_WIDE]) begin
         nxt_shadow = count_ff[15:8];
      end
      if (wr_high) begin
         if (ctrl_ff[`GTC_CTRL_WIDE]) begin
            nxt_shadow = wb;
         end else begin
            nxt_count = {wb, nxt_count[7:0]};
         end
         nxt_armed = 1'b0;
      end
      if (wr_low) begin
         if (ctrl_ff[`GTC_CTRL_WIDE]) begin
            nxt_count = {shadow_ff, wb};
         end else begin
            nxt_count = {nxt_count[15:8], wb};
         end
         nxt_psc = 3'h0;
         nxt_armed = 1'b0;
      end
      // a hardware set wins over a software clear
      if (wr_stat && !wb[`GTC_STAT_OVF]
            && !(pre_out && sum[`GTC_SUM_CARRY])) begin
         nxt_ovf = 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         count_ff <= 16'h0000;
         shadow_ff <= 8'h00;
         psc_ff <= 3'h0;
         ovf_ff <= 1'b0;
         src_q_ff <= 1'b0;
         armed_ff <= 1'b0;
         overflow_pulse <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         shadow_ff <= nxt_shadow;
         psc_ff <= nxt_psc;
         ovf_ff <= nxt_ovf;
         src_q_ff <= src;
         armed_ff <= nxt_armed;
         overflow_pulse <= pre_out && sum[`GTC_SUM_CARRY];
      end
   end

   // control and clock-select registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= 6'h00;
         clk_ff <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wb[`GTC_CTRL_PS_HI:0];
         end
         if (wr_clk) begin
            clk_ff <= wb[`GTC_CLK_LSO_EN:0];
         end
      end
   end

   // read mux; count sampled in the clock domain so reads are whole
   always @* begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_axi_araddr[`GTC_ADDR_SEL]) begin
         rd_ok = rd_stat;
         if (rd_stat) begin
            rd_word[`GTC_STAT_OVF] = ovf_ff;
            rd_word[`GTC_STAT_LSO_RDY] = lso_ready;
         end
      end else begin
         case (ra)
            `GTC_ADDR_LOW: rd_word[7:0] = count_ff[7:0];
            `GTC_ADDR_HIGH: rd_word[7:0] = ctrl_ff[`GTC_CTRL_WIDE]
               ? shadow_ff : count_ff[15:8];
            `GTC_ADDR_CTRL: rd_word[5:0] = ctrl_ff;
            `GTC_ADDR_CLK: rd_word[2:0] = clk_ff;
            default: rd_ok = 1'b0;
         endcase
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GTC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `GTC_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? `GTC_RESP_OKAY : `GTC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `GTC_RESP_OKAY : `GTC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // gtc_timer
`default_nettype wire

// [test/gtc_ext_src.sv]
`timescale 1ns/100ps
`default_nettype none
// external count source: toggles every 4 cycles, idles low outside bursts
module gtc_ext_src (
   input wire logic aclk,
   input wire logic ext_en,
   output var logic ext_clock_input
);
   logic [1:0] cnt_ff;
   always @(posedge aclk) begin
      cnt_ff <= ext_en ? cnt_ff + 2'h1 : 2'h0;
      if (!ext_en) begin
         ext_clock_input <= 1'b0;
      end else if (cnt_ff == 2'h3) begin
         ext_clock_input <= !ext_clock_input;
      end
   end
endmodule // gtc_ext_src
`default_nettype wire

// [test/gtc_timer_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module gtc_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic lso_enable,
   input wire logic overflow_pulse
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
   endproperty
   property p_bh;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_bref;
      s_axi_bvalid |-> !s_axi_awready;
   endproperty
   property p_rd;
      s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
   endproperty
   property p_rh;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_ovf;
      overflow_pulse |=> !overflow_pulse;
   endproperty
   property p_lso;
      !(s_axi_awvalid && s_axi_wvalid) |=> $stable(lso_enable);
   endproperty
   property p_rst;
      disable iff (1'b0)
      !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !lso_enable;
   endproperty
   a_wr: assert property (p_wr) else $error("write unanswered");
   a_bh: assert property (p_bh) else $error("bvalid dropped");
   a_bref: assert property (p_bref) else $error("write taken");
   a_rd: assert property (p_rd) else $error("read unanswered");
   a_rh: assert property (p_rh) else $error("rdata moved");
   a_ovf: assert property (p_ovf) else $error("long overflow");
   a_lso: assert property (p_lso) else $error("lso moved");
   a_rst: assert property (p_rst) else $error("reset state");
   c_ovf: cover property (overflow_pulse);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // gtc_chk
bind gtc_timer gtc_chk u_chk (.*);
`default_nettype wire

// [test/gtc_timer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module gtc_timer_tb;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, ext_en = 1'b0, fosc_tick = 1'b0;
   logic fosc4_tick = 1'b0, lso_ready = 1'b0, lso_clk;
   logic gate_in = 1'b0, sleep = 1'b0, ext_clock_input;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, lso_enable, overflow_pulse;
   logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   int fails = 0, checked = 0, cyc = 0, novf = 0;
   typedef struct {logic w; logic [4:0] a; logic [31:0] d;} gtc_row_t;
   gtc_row_t rows [6] = '{'{1'b0, 5'h00, 32'h0}, '{1'b0, 5'h08, 32'h0},
      '{1'b1, 5'h04, 32'h9A}, '{1'b0, 5'h04, 32'h9A},
      '{1'b1, 5'h00, 32'hBC}, '{1'b0, 5'h00, 32'hBC}};
   gtc_timer dut (.*);
   gtc_ext_src u_src (.*);
   assign lso_clk = ext_clock_input; // low-speed source shares the model
   initial forever #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      novf += (overflow_pulse === 1'b1);
      if (cyc == 6000) begin
         fails++;
         conclude;
      end
   end
   task conclude;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      bresp_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [4:0] a, input logic [31:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(e, s_axi_rdata);
   endtask
   task tk(input int n, input logic full);
      repeat (n) begin
         @(posedge aclk);
         fosc_tick <= full;
         fosc4_tick <= !full;
         @(posedge aclk);
         fosc_tick <= 1'b0;
         fosc4_tick <= 1'b0;
      end
   endtask
   task burst;
      @(posedge aclk);
      ext_en <= 1'b1;
      repeat (24) @(posedge aclk);
      ext_en <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         else rd(rows[i].a, rows[i].d);
      end
      rd(5'h14, 32'h0);
      chk(32'h2, s_axi_rresp);
      wr(5'h14, 32'h0);
      chk(32'h2, bresp_q);
      for (int p = 0; p < 4; p++) begin
         wr(5'h00, 32'h0);
         wr(5'h08, 32'h1 | (p << 4));
         tk(8, 1'b0);
         wr(5'h08, 32'h0);
         rd(5'h00, 32'h8 >> p);
      end
      wr(5'h08, 32'h31);
      wr(5'h00, 32'h0);
      tk(4, 1'b0);
      wr(5'h04, 32'h0);
      tk(4, 1'b0);
      rd(5'h00, 32'h1);
      wr(5'h00, 32'h0);
      tk(4, 1'b0);
      wr(5'h00, 32'h0);
      tk(4, 1'b0);
      rd(5'h00, 32'h0);
      wr(5'h08, 32'h9);
      tk(4, 1'b0);
      gate_in <= 1'b1; // gate opens, internal source counts
      tk(4, 1'b0);
      rd(5'h00, 32'h4);
      wr(5'h0C, 32'h1);
      wr(5'h00, 32'h0);
      wr(5'h08, 32'h1);
      tk(3, 1'b1);
      rd(5'h00, 32'hC);
      wr(5'h0C, 32'h0);
      wr(5'h04, 32'hFF);
      wr(5'h00, 32'hFE);
      tk(2, 1'b0);
      wr(5'h08, 32'h0);
      rd(5'h04, 32'h0);
      chk(32'h1, novf);
      lso_ready <= 1'b1;
      rd(5'h10, 32'h3);
      wr(5'h10, 32'h0);
      rd(5'h10, 32'h2);
      wr(5'h0C, 32'h4);
      chk(32'h0, bresp_q);
      chk(32'h1, lso_enable);
      wr(5'h08, 32'h2);
      wr(5'h04, 32'h56);
      wr(5'h00, 32'h78);
      wr(5'h08, 32'h0);
      rd(5'h04, 32'h56);
      wr(5'h08, 32'h2);
      wr(5'h04, 32'hAA);
      rd(5'h04, 32'hAA);
      rd(5'h00, 32'h78);
      rd(5'h04, 32'h56);
      wr(5'h0C, 32'h2);
      wr(5'h00, 32'h0);
      wr(5'h08, 32'h1);
      burst;
      rd(5'h00, 32'h2);
      sleep <= 1'b1;
      burst;
      sleep <= 1'b0;
      rd(5'h00, 32'h2);
      wr(5'h00, 32'h0); // written while still synchronized
      wr(5'h08, 32'h5);
      sleep <= 1'b1;
      burst;
      sleep <= 1'b0;
      rd(5'h00, 32'h2);
      wr(5'h08, 32'h4); // stopped before an async write
      wr(5'h0C, 32'h7); // oscillator already ready
      wr(5'h00, 32'h0);
      wr(5'h08, 32'h5);
      sleep <= 1'b1;
      burst;
      sleep <= 1'b0;
      rd(5'h00, 32'h2);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(5'h00, 32'h0);
      rd(5'h04, 32'h0);
      chk(32'h0, lso_enable);
      conclude;
   end
endmodule // gtc_timer_tb
`default_nettype wire
